//--- verilog/tast_timer.sv
// module: trigger acquisition sequencer with single and continuous strobes
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Functional notes
// RULE_01: rising trigger edge starts acquisition in edge mode
// RULE_02: trigger event follows pin edge quickly
// RULE_03: busy plus delay, integration, final busy
// RULE_04: delays and strobes set in microsecond steps
// RULE_05: level mode integration equals pulse width
// RULE_06: single strobe rises after delay from event
// RULE_07: single strobe stays high for its width
// RULE_08: single strobe forced low at integration end
// RULE_09: continuous strobe starts with integration
// RULE_10: only whole continuous strobe periods emitted; level mode can cut a period at integration end
// RULE_11: continuous strobe low when integration ends
// RULE_12: continuous strobe half high, half low
// RULE_13: new trigger accepted only after final busy
// RULE_14: all intervals counted on microsecond tick
module tast_timer
  import tast_pkg::*;
#(
  parameter int P_INIT_BUSY_US = INIT_BUSY_US,
  parameter int P_FINAL_BUSY_US = FINAL_BUSY_US
) (
  input wire logic CLK_SYS_I,                 // system clock, 25 MHz
  input wire logic SRST_I,                    // sync reset, active high
  input wire logic TRIG_I,                    // external trigger pin
  output logic SS_O,                          // single strobe
  output logic CS_O,                          // continuous strobe
  output logic INTEG_O,                       // integration window
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I, // write address
  input wire logic S_AXI_AWVALID_I,           // write address valid
  output logic S_AXI_AWREADY_O,               // write address ready
  input wire logic [31:0] S_AXI_WDATA_I,      // write data
  input wire logic [3:0] S_AXI_WSTRB_I,       // write byte enables
  input wire logic S_AXI_WVALID_I,            // write data valid
  output logic S_AXI_WREADY_O,                // write data ready
  output logic [1:0] S_AXI_BRESP_O,           // write response
  output logic S_AXI_BVALID_O,                // write response valid
  input wire logic S_AXI_BREADY_I,            // write response ready
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I, // read address
  input wire logic S_AXI_ARVALID_I,           // read address valid
  output logic S_AXI_ARREADY_O,               // read address ready
  output logic [31:0] S_AXI_RDATA_O,          // read data
  output logic [1:0] S_AXI_RRESP_O,           // read response
  output logic S_AXI_RVALID_O,                // read data valid
  input wire logic S_AXI_RREADY_I             // read data ready
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // true when cnt elapsed ticks plus this one reach len
  function automatic logic reached(input logic [31:0] cnt, input logic [31:0] len);
    return ({1'b0, cnt} + 33'd1) >= {1'b0, len};
  endfunction

  // true when a period starting at tick ph completes within len
  function automatic logic fits(input logic [31:0] len, input logic [31:0] ph,
                                input logic [31:0] per);
    return {1'b0, len} >= ({1'b0, ph} + {1'b0, per});
  endfunction

  // ------------------------------------------------------------
  // tick and trigger synchroniser
  // ------------------------------------------------------------
  tast_evt_if evt ();

  tast_tick u_tick (
    .clk_i(CLK_SYS_I),
    .srst_i(SRST_I),
    .evt(evt.tick_src)
  );

  tast_sync u_sync (
    .clk_i(CLK_SYS_I),
    .srst_i(SRST_I),
    .trig_i(TRIG_I),
    .evt(evt.sync_src)
  );

  // ------------------------------------------------------------
  // registers and bus state
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] acq_q;
  logic [31:0] integ_q;
  logic [31:0] ss_dly_q;
  logic [31:0] ss_wid_q;
  logic [31:0] cs_per_q;
  logic [31:0] cycles_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_full_q;
  logic w_full_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  tast_state_t st_q;
  tast_state_t st_d;
  logic [31:0] ph_cnt_q;
  logic [31:0] ss_cnt_q;
  logic ss_cut_q;
  logic [31:0] lw_q;
  logic ldone_q;
  logic ss_q;
  logic cs_q;
  logic cs_run_q;
  logic [31:0] cs_cnt_q;
  logic integ_q_o;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire aw_take = S_AXI_AWVALID_I & awready_q;
  wire w_take = S_AXI_WVALID_I & wready_q;
  wire ar_take = S_AXI_ARVALID_I & arready_q;
  wire wr_do = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = (aw_full_q | aw_take) & ~wr_do;
  wire w_full_d = (w_full_q | w_take) & ~wr_do;
  wire bvalid_d = (bvalid_q & ~S_AXI_BREADY_I) | wr_do;
  wire rvalid_d = (rvalid_q & ~S_AXI_RREADY_I) | ar_take;
  wire wr_ctrl = wr_do & (awaddr_q == ADDR_CTRL);
  wire wr_acq = wr_do & (awaddr_q == ADDR_ACQ_DELAY);
  wire wr_integ = wr_do & (awaddr_q == ADDR_INTEG_TIME);
  wire wr_ssd = wr_do & (awaddr_q == ADDR_SS_DELAY);
  wire wr_ssw = wr_do & (awaddr_q == ADDR_SS_WIDTH);
  wire wr_csp = wr_do & (awaddr_q == ADDR_CS_PERIOD);
  wire wr_hit = wr_ctrl | wr_acq | wr_integ | wr_ssd | wr_ssw | wr_csp;
  wire [31:0] acq_new = merge(acq_q, wdata_q, wstrb_q);
  wire [31:0] acq_clip = (acq_new > ACQ_DELAY_MAX_US) ? ACQ_DELAY_MAX_US : acq_new;
  wire [31:0] status = {24'h00_0000, evt.trig_lvl, ldone_q, cs_q, ss_q, st_q};
  wire rd_hit = (S_AXI_ARADDR_I <= ADDR_CYCLE_COUNT) & (S_AXI_ARADDR_I[1:0] == 2'h0);
  wire [31:0] rd_mux =
    (S_AXI_ARADDR_I == ADDR_CTRL) ? ctrl_q :
    (S_AXI_ARADDR_I == ADDR_ACQ_DELAY) ? acq_q :
    (S_AXI_ARADDR_I == ADDR_INTEG_TIME) ? integ_q :
    (S_AXI_ARADDR_I == ADDR_SS_DELAY) ? ss_dly_q :
    (S_AXI_ARADDR_I == ADDR_SS_WIDTH) ? ss_wid_q :
    (S_AXI_ARADDR_I == ADDR_CS_PERIOD) ? cs_per_q :
    (S_AXI_ARADDR_I == ADDR_STATUS) ? status :
    (S_AXI_ARADDR_I == ADDR_LEVEL_WIDTH) ? lw_q :
    (S_AXI_ARADDR_I == ADDR_CYCLE_COUNT) ? cycles_q : 32'h0000_0000;

  // ------------------------------------------------------------
  // sequencer decode
  // ------------------------------------------------------------
  wire en = ctrl_q[CTRL_EN_BIT];
  wire lvl_mode = ctrl_q[CTRL_LEVEL_BIT];
  wire active = (st_q != ST_IDLE);
  wire start = (st_q == ST_IDLE) & en & evt.trig_rise;
  wire [31:0] delay_len = 32'(P_INIT_BUSY_US) + acq_q;
  wire len_known = ~lvl_mode | ldone_q;
  wire [31:0] integ_len = lvl_mode ? lw_q : integ_q;
  wire delay_last = (st_q == ST_DELAY) & evt.tick & reached(ph_cnt_q, delay_len);
  wire integ_end = (st_q == ST_INTEG) & evt.tick & len_known & reached(ph_cnt_q, integ_len);
  wire final_last = (st_q == ST_FINAL) & evt.tick &
                    reached(ph_cnt_q, 32'(P_FINAL_BUSY_US));
  wire phase_chg = start | delay_last | integ_end | final_last;
  wire [31:0] ss_end = ss_dly_q + ss_wid_q;
  wire ss_win = (ss_cnt_q >= ss_dly_q) & ({1'b0, ss_cnt_q} < ({1'b0, ss_dly_q} + {1'b0, ss_wid_q}));
  wire ss_d = active & ~ss_cut_q & ~integ_end & ss_win;
  wire [31:0] cs_half = cs_per_q >> 1;
  wire cs_wrap = evt.tick & cs_run_q & ((cs_cnt_q + 32'd1) == cs_per_q);
  wire cs_fit0 = (cs_per_q != 32'd0) & (~len_known | fits(integ_len, 32'd0, cs_per_q));
  wire cs_fitn = ~len_known | fits(integ_len, ph_cnt_q + 32'd1, cs_per_q);
  wire cs_run_d = delay_last ? cs_fit0 :
                  integ_end ? 1'b0 :
                  cs_wrap ? (cs_run_q & cs_fitn) : cs_run_q;
  wire [31:0] cs_cnt_d = (delay_last | cs_wrap) ? 32'd0 :
                         (evt.tick & cs_run_q) ? cs_cnt_q + 32'd1 : cs_cnt_q;
  wire cs_d = cs_run_d & (cs_cnt_d < cs_half) & ~integ_end;

  always_comb begin
    case (st_q)
      ST_IDLE: st_d = start ? ST_DELAY : ST_IDLE; // RULE_01 RULE_13
      ST_DELAY: st_d = delay_last ? ST_INTEG : ST_DELAY; // RULE_03
      ST_INTEG: st_d = integ_end ? ST_FINAL : ST_INTEG; // RULE_03 RULE_05
      ST_FINAL: st_d = final_last ? ST_IDLE : ST_FINAL; // RULE_13
      default: st_d = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (aw_take) begin
        awaddr_q <= S_AXI_AWADDR_I;
      end
      if (w_take) begin
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
      end
      if (wr_do) begin
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------
  // settings
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ctrl_q <= CTRL_RESET;
      acq_q <= 32'h0000_0000;
      integ_q <= INTEG_RESET;
      ss_dly_q <= 32'h0000_0000;
      ss_wid_q <= 32'h0000_0000;
      cs_per_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0003;
      if (wr_acq) acq_q <= acq_clip; // RULE_04
      if (wr_integ) integ_q <= merge(integ_q, wdata_q, wstrb_q);
      if (wr_ssd) ss_dly_q <= merge(ss_dly_q, wdata_q, wstrb_q); // RULE_04
      if (wr_ssw) ss_wid_q <= merge(ss_wid_q, wdata_q, wstrb_q);
      if (wr_csp) cs_per_q <= merge(cs_per_q, wdata_q, wstrb_q);
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      st_q <= ST_IDLE;
      ph_cnt_q <= 32'h0000_0000;
      cycles_q <= 32'h0000_0000;
      ss_cnt_q <= 32'h0000_0000;
      ss_cut_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (phase_chg) ph_cnt_q <= 32'h0000_0000; // RULE_14
      else if (evt.tick) ph_cnt_q <= ph_cnt_q + 32'd1;
      if (final_last) cycles_q <= cycles_q + 32'd1;
      if (start) ss_cnt_q <= 32'h0000_0000; // RULE_06
      else if (evt.tick & active & ~(&ss_cnt_q)) ss_cnt_q <= ss_cnt_q + 32'd1;
      if (start) ss_cut_q <= 1'b0;
      else if (integ_end) ss_cut_q <= 1'b1; // RULE_08
    end
  end

  // level mode: pulse width measured in ticks from the event
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      lw_q <= 32'h0000_0000;
      ldone_q <= 1'b0;
    end else if (start) begin
      lw_q <= 32'h0000_0000;
      ldone_q <= 1'b0;
    end else begin
      if (active & ~ldone_q & evt.trig_fall) ldone_q <= 1'b1; // RULE_05
      if (active & ~ldone_q & evt.trig_lvl & evt.tick) lw_q <= lw_q + 32'd1;
    end
  end

  // ------------------------------------------------------------
  // strobes
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ss_q <= 1'b0;
      cs_q <= 1'b0;
      cs_run_q <= 1'b0;
      cs_cnt_q <= 32'h0000_0000;
      integ_q_o <= 1'b0;
    end else begin
      ss_q <= ss_d; // RULE_06 RULE_07 RULE_08
      cs_run_q <= cs_run_d; // RULE_09 RULE_10
      cs_cnt_q <= cs_cnt_d;
      cs_q <= cs_d; // RULE_11 RULE_12
      integ_q_o <= (st_d == ST_INTEG);
    end
  end

  assign SS_O = ss_q;
  assign CS_O = cs_q;
  assign INTEG_O = integ_q_o;
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O = wready_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign S_AXI_RVALID_O = rvalid_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SRST_I);

  logic [TICK_W-1:0] gap_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) gap_q <= '1; // first tick after reset lands one edge later
    else if (evt.tick) gap_q <= '0;
    else gap_q <= gap_q + TICK_W'(1);
  end

  sequence s_idle_rise;
    (st_q == ST_IDLE) && en && evt.trig_rise;
  endsequence
  sequence s_delay_run;
    (st_q == ST_DELAY) [*2];
  endsequence

  property p_edge_start;
    s_idle_rise |=> s_delay_run;
  endproperty
  a_edge_start: assert property (p_edge_start) // RULE_01
    else $error("trigger edge did not start a cycle");

  property p_event_latency;
    evt.trig_rise |-> $past(TRIG_I, 3) && $past(TRIG_I, 4);
  endproperty
  a_event_latency: assert property (p_event_latency) // RULE_02
    else $error("trigger event without pin edge");

  property p_integ_order;
    $rose(st_q == ST_INTEG) |-> $past(st_q) == ST_DELAY && $past(reached(ph_cnt_q, delay_len));
  endproperty
  a_integ_order: assert property (p_integ_order) // RULE_03
    else $error("integration started early");

  property p_acq_limit;
    acq_q <= ACQ_DELAY_MAX_US;
  endproperty
  a_acq_limit: assert property (p_acq_limit) // RULE_04
    else $error("acquisition delay above limit");

  property p_level_end;
    $rose(st_q == ST_FINAL) && lvl_mode |-> ldone_q && ($past(ph_cnt_q) + 32'd1 >= lw_q);
  endproperty
  a_level_end: assert property (p_level_end) // RULE_05
    else $error("level integration ended off pulse width");

  property p_ss_rise;
    $rose(ss_q) |-> $past(ss_cnt_q >= ss_dly_q) && $past(active);
  endproperty
  a_ss_rise: assert property (p_ss_rise) // RULE_06
    else $error("single strobe rose before its delay");

  property p_ss_fall;
    $fell(ss_q) |-> $past(ss_cnt_q >= ss_end) || $past(integ_end);
  endproperty
  a_ss_fall: assert property (p_ss_fall) // RULE_07
    else $error("single strobe fell before its width");

  property p_ss_cut;
    integ_end |=> !ss_q ##1 !ss_q;
  endproperty
  a_ss_cut: assert property (p_ss_cut) // RULE_08
    else $error("single strobe high after integration");

  property p_cs_begin;
    delay_last && cs_per_q >= 32'd2 && cs_fit0 |=> cs_q && (st_q == ST_INTEG);
  endproperty
  a_cs_begin: assert property (p_cs_begin) // RULE_09
    else $error("continuous strobe missed integration start");

  property p_cs_whole;
    cs_wrap && len_known && !fits(integ_len, ph_cnt_q + 32'd1, cs_per_q) |=> !cs_run_q;
  endproperty
  a_cs_whole: assert property (p_cs_whole) // RULE_10
    else $error("partial continuous strobe period begun");

  property p_cs_off;
    st_q != ST_INTEG |-> !cs_q;
  endproperty
  a_cs_off: assert property (p_cs_off) // RULE_11
    else $error("continuous strobe high outside integration");

  property p_cs_duty;
    $fell(cs_q) && (st_q == ST_INTEG) |-> cs_cnt_q == cs_half;
  endproperty
  a_cs_duty: assert property (p_cs_duty) // RULE_12
    else $error("continuous strobe duty not half");

  property p_no_retrigger;
    active && evt.trig_rise && !final_last |=> st_q != ST_IDLE && st_q != ST_DELAY ||
      $past(st_q) == ST_DELAY;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) // RULE_13
    else $error("trigger accepted during a cycle");

  property p_tick_gap;
    evt.tick |-> gap_q == TICK_LAST;
  endproperty
  a_tick_gap: assert property (p_tick_gap) // RULE_14
    else $error("microsecond tick spacing wrong");
endmodule

//--- include/tast_pkg.sv
// package: constants, register map and types of the acquisition strobe timer
package tast_pkg;
  // ------------------------------------------------------------
  // timebase
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int US_NS = 1000;
  localparam int TICK_CYC = US_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 5;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam int TRIG_LAT_MIN_NS = 20;
  localparam int TRIG_LAT_MAX_NS = 30;
  localparam int TRIG_LAT_MAX_CYC =
    (TRIG_LAT_MAX_NS / CLK_PERIOD_NS < 1) ? 1 : TRIG_LAT_MAX_NS / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // acquisition intervals, in microseconds; LEVEL_MAX_S in seconds
  // ------------------------------------------------------------
  localparam int INIT_BUSY_US = 1094;
  localparam int FINAL_BUSY_US = 1038;
  localparam logic [31:0] ACQ_DELAY_MAX_US = 32'd335500;
  localparam int LEVEL_MIN_US = 6;
  localparam int LEVEL_MAX_S = 10;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ACQ_DELAY = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_INTEG_TIME = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SS_DELAY = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_SS_WIDTH = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CS_PERIOD = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_WIDTH = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_CYCLE_COUNT = 8'h20;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LEVEL_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] INTEG_RESET = 32'h0000_0064;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DELAY = 4'h2,
    ST_INTEG = 4'h4,
    ST_FINAL = 4'h8
  } tast_state_t;
endpackage

//--- include/tast_evt_if.sv
// interface: microsecond tick and synchronised trigger events
`timescale 1ns/100ps
interface tast_evt_if;
  logic tick;
  logic trig_lvl;
  logic trig_rise;
  logic trig_fall;
  modport tick_src (output tick);
  modport sync_src (output trig_lvl, output trig_rise, output trig_fall);
  modport core (input tick, input trig_lvl, input trig_rise, input trig_fall);
endinterface

//--- verilog/tast_tick.sv
// module: one microsecond tick from the system clock
`timescale 1ns/100ps
module tast_tick
  import tast_pkg::*;
(
  input wire logic clk_i,           // system clock
  input wire logic srst_i,          // sync reset, active high
  tast_evt_if.tick_src evt          // tick out
);
  logic [TICK_W-1:0] cnt_q;
  logic tick_q;
  wire wrap = (cnt_q == TICK_LAST);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + TICK_W'(1);
      tick_q <= wrap; // RULE_14
    end
  end

  assign evt.tick = tick_q;
endmodule

//--- verilog/tast_sync.sv
// module: trigger pin synchroniser with edge events
`timescale 1ns/100ps
module tast_sync
  import tast_pkg::*;
(
  input wire logic clk_i,           // system clock
  input wire logic srst_i,          // sync reset, active high
  input wire logic trig_i,          // raw trigger pin
  tast_evt_if.sync_src evt          // level and edges out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic rise_q;
  logic fall_q;
  wire agree = (s2_q == s3_q);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q <= trig_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s2_q;
      end
      rise_q <= agree & s2_q & ~lvl_q; // RULE_01 RULE_02
      fall_q <= agree & ~s2_q & lvl_q;
    end
  end

  assign evt.trig_lvl = lvl_q;
  assign evt.trig_rise = rise_q;
  assign evt.trig_fall = fall_q;
endmodule

//--- bench/tast_trig_src.sv
// trigger source model driving the external trigger pin
`timescale 1ns/100ps
module tast_trig_src (
  input wire logic clk_i, // system clock
  output logic trig_o     // trigger pin
);
  initial trig_o = 1'h0;
  // pulse of whole cycles; the level run keeps it within 6 us and 10 s, the edge run uses 2 us and 10 us
  task automatic pulse(input int cyc);
    @(posedge clk_i);
    trig_o <= 1'h1;
    repeat (cyc) @(posedge clk_i);
    trig_o <= 1'h0;
  endtask
endmodule

//--- bench/test_trigger_acquisition_strobe_timer.sv
// self-checking bench of the acquisition strobe timer
`timescale 1ns/100ps
module test_trigger_acquisition_strobe_timer;
  import tast_pkg::*;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, ss, cs, integ, trig, cs_q;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int errors = 0, samples_checked = 0, cycles = 0, n, rises = 0, hi = 0, seed = 73128;

  always #20 clk = ~clk;
  tast_trig_src tast_trig_src_inst (.clk_i(clk), .trig_o(trig));
  tast_timer #(.P_INIT_BUSY_US(10), .P_FINAL_BUSY_US(8)) tast_timer_inst (
    .CLK_SYS_I(clk), .SRST_I(srst), .TRIG_I(trig), .SS_O(ss), .CS_O(cs), .INTEG_O(integ),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input int exp, input int got, input int tol);
    samples_checked++;
    if (got < exp - tol || got > exp + tol) begin
      errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask

  task automatic wait_for(input bit s, input logic lvl, output int c);
    c = 0;
    while ((s ? ss : integ) !== lvl && c < 4000) begin
      @(posedge clk);
      c++;
    end
  endtask

  // --------------------------------------------------------------
  // output watcher and timeout
  // --------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    cs_q <= cs;
    if (integ === 1'h1 && cs === 1'h1) hi++;
    if (integ === 1'h1 && cs === 1'h1 && cs_q !== 1'h1) rises++;
    if (rvalid === 1'h1 && rready && rq.size() > 0) begin
      samples_checked++;
      if ({rresp, rdata} !== rq[0]) begin
        errors++;
        $display("MISMATCH read expected %h seen %h", rq[0], {rresp, rdata});
      end
      void'(rq.pop_front());
    end
    if (bvalid === 1'h1 && bready && bq.size() > 0) begin
      samples_checked++;
      if (bresp !== bq[0]) begin
        errors++;
        $display("MISMATCH bresp expected %h seen %h", bq[0], bresp);
      end
      void'(bq.pop_front());
    end
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    rd(ADDR_CTRL, {RESP_OKAY, CTRL_RESET});
    rd(ADDR_INTEG_TIME, {RESP_OKAY, INTEG_RESET});
    rd(8'h40, {RESP_SLVERR, 32'h0});
    wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
    wr(ADDR_ACQ_DELAY, 32'h51E8D, RESP_OKAY);
    rd(ADDR_ACQ_DELAY, {RESP_OKAY, ACQ_DELAY_MAX_US});
    v = 32'($random(seed)) & 32'h3;
    wr(ADDR_ACQ_DELAY, v, RESP_OKAY);
    rd(ADDR_ACQ_DELAY, {RESP_OKAY, v});
    wstrb <= 4'h1;
    wr(ADDR_INTEG_TIME, 32'hFFFF_FF15, RESP_OKAY);
    wstrb <= 4'hF;
    rd(ADDR_INTEG_TIME, {RESP_OKAY, 32'h15});
    wr(ADDR_SS_DELAY, v + 32'hC, RESP_OKAY);
    wr(ADDR_SS_WIDTH, 32'h3E8, RESP_OKAY);
    wr(ADDR_CS_PERIOD, 32'h4, RESP_OKAY);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    $display("register test done");
    // edge run: busy 10 us plus delay, 21 us integration, period 4 us
    fork tast_trig_src_inst.pulse(50); join_none
    wait_for(1'b0, 1'h1, n);
    check("integ start", 5 + (10 + int'(v)) * 25, n, 26);
    wait_for(1'b1, 1'h1, n);
    check("single strobe rise", 50, n, 26);
    wait_for(1'b0, 1'h0, n);
    check("integ length", 21 * 25 - 50, n, 26);
    @(posedge clk);
    check("single strobe low", 0, int'(ss !== 1'h0), 0);
    check("cont strobe low", 0, int'(cs !== 1'h0), 0);
    check("cont strobe periods", 5, rises, 0);
    check("cont strobe high time", 5 * 50, hi, 5);
    // trigger during final busy must be ignored
    fork tast_trig_src_inst.pulse(250); join_none
    repeat (1500) @(posedge clk);
    rd(ADDR_CYCLE_COUNT, {RESP_OKAY, 32'h1});
    $display("edge test done");
    // level run: integration follows a 30 us pulse
    wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    fork tast_trig_src_inst.pulse(750); join_none
    wait_for(1'b0, 1'h1, n);
    check("level integ start", 5 + (10 + int'(v)) * 25, n, 26);
    wait_for(1'b0, 1'h0, n);
    check("level integ length", 750, n, 26);
    repeat (300) @(posedge clk);
    rd(ADDR_CYCLE_COUNT, {RESP_OKAY, 32'h2});
    $display("level test done");
    end_of_test();
  end
endmodule
